// File: design/ssf_startup_seq.sv
`timescale 1ns/1ps
// Function
// - ramp output over rise-time word (ms) starting right after enable
// - 16-bit timeout limit in ms; fault if undervoltage limit not reached
// - timeout limit zero disables the startup fault entirely
// - response register is a byte; rise time and limit are words
// - response bits 7:6 choose the startup fault reaction
// - selector 00 ignores the fault, output keeps running
// - selector 01 runs on for the delay, then applies retry field
// - selector 10 disables output at once, then applies retry field
// - selector 11 stays off until fault cleared or off-then-on
// - retry field 000 makes no restart, stays off until cleared
// - retry 001..101 restarts that many times, then stays off
// - restart spacing is two to the power delay count times fault delay unit
// - delay count 0..7 selects 1..128 delay units, powers of two
// - retry 110 means six restarts; 111 restarts without limit
// - delay unit comes from a separate configuration setting
// - the unit used is the output-overvoltage fault time unit
module ssf_startup_seq
  import ssf_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CLK_PER_MS,
  parameter logic [6:0]  BUS_ADDR  = BUS_ADDR_DEF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // pmbus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // power stage control
  input  wire logic        ramp_go,
  input  wire logic        clear_faults,
  input  wire logic        vout_above_uv,
  input  wire logic [7:0]  ov_fault_time_unit,
  // status
  output logic             output_enable,
  output logic             ramp_active,
  output logic             ramp_done,
  output logic [15:0]      ramp_ms,
  output logic             startup_fault,
  output logic [2:0]       retry_count
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] fault_delay(input logic [2:0] code,
                                              input logic [7:0] unit);
    fault_delay = {8'h00, unit} << code;
  endfunction : fault_delay

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == CMD_RISE) || (c == CMD_LIMIT) || (c == CMD_RESP);
  endfunction : known_cmd

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [1:0] uv_sync_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      uv_sync_reg  <= 2'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      uv_sync_reg  <= {uv_sync_reg[0], vout_above_uv};
    end
  end

  logic scl_s, sda_s, vout_ok;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign vout_ok   = uv_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_s & scl_sync_reg[2];
  assign bus_start = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
  assign bus_stop  = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];

  // ---------------------------------------------------------------
  // pmbus slave and register file
  // ---------------------------------------------------------------
  ssf_bus_e    bus_reg, bus_next;
  logic [3:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [1:0]  idx_reg, idx_next;
  logic        drv_reg, drv_next;
  logic [7:0]  lo_reg, lo_next;
  logic [15:0] rise_reg, rise_next;
  logic [15:0] lim_reg, lim_next;
  logic [7:0]  resp_reg, resp_next;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;

  always_comb begin
    case (cmd_reg)
      CMD_RISE:  rd_word = rise_reg;
      CMD_LIMIT: rd_word = lim_reg;
      CMD_RESP:  rd_word = {8'h00, resp_reg};
      default:   rd_word = 16'h0000;
    endcase
    case (idx_reg)
      2'd0:    rd_byte = rd_word[7:0];
      2'd1:    rd_byte = rd_word[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    bus_next  = bus_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    cmd_next  = cmd_reg;
    idx_next  = idx_reg;
    drv_next  = drv_reg;
    lo_next   = lo_reg;
    rise_next = rise_reg;
    lim_next  = lim_reg;
    resp_next = resp_reg;
    if (bus_start) begin
      bus_next = BS_ADDR;
      // the scl fall that closes a start is not a bit: it wraps to zero
      bit_next = 4'hf;
      idx_next = 2'd0;
      drv_next = 1'b0;
    end else if (bus_stop) begin
      bus_next = BS_IDLE;
      drv_next = 1'b0;
    end else if (bus_reg != BS_IDLE && scl_rise) begin
      if (bus_reg == BS_RD) begin
        // master nack ends the read
        if (bit_reg == 4'd8 && sda_s) begin
          bus_next = BS_IDLE;
        end
      end else if (bit_reg != 4'd8) begin
        sh_next = {sh_reg[6:0], sda_s};
      end
    end else if (bus_reg != BS_IDLE && scl_fall) begin
      if (bit_reg == 4'd7) begin
        bit_next = 4'd8;
        drv_next = 1'b1;
        case (bus_reg)
          BS_ADDR: begin
            if (sh_reg[7:1] != BUS_ADDR) begin
              drv_next = 1'b0;
              bus_next = BS_IDLE;
            end
          end
          BS_CMD: begin
            cmd_next = sh_reg;
            idx_next = 2'd0;
            if (!known_cmd(sh_reg)) begin
              drv_next = 1'b0;
              bus_next = BS_IDLE;
            end
          end
          BS_WR: begin
            if (idx_reg == 2'd0) begin
              lo_next = sh_reg;
              if (cmd_reg == CMD_RESP) begin
                resp_next = sh_reg;
              end
            end else if (idx_reg == 2'd1) begin
              // word takes effect only when the high byte lands
              if (cmd_reg == CMD_RISE) begin
                rise_next = {sh_reg, lo_reg};
              end
              if (cmd_reg == CMD_LIMIT) begin
                lim_next = {sh_reg, lo_reg};
              end
            end
            if (idx_reg != 2'd3) begin
              idx_next = idx_reg + 2'd1;
            end
          end
          default: drv_next = 1'b0;
        endcase
      end else if (bit_reg == 4'd8) begin
        bit_next = 4'd0;
        drv_next = 1'b0;
        case (bus_reg)
          BS_ADDR: begin
            if (sh_reg[0]) begin
              bus_next = BS_RD;
              sh_next  = rd_byte;
              drv_next = ~rd_byte[7];
              idx_next = idx_reg + 2'd1;
            end else begin
              bus_next = BS_CMD;
            end
          end
          BS_CMD: bus_next = BS_WR;
          BS_RD: begin
            sh_next  = rd_byte;
            drv_next = ~rd_byte[7];
            if (idx_reg != 2'd3) begin
              idx_next = idx_reg + 2'd1;
            end
          end
          default: bus_next = bus_reg;
        endcase
      end else begin
        bit_next = bit_reg + 4'd1;
        if (bus_reg == BS_RD) begin
          drv_next = ~sh_reg[6];
          sh_next  = {sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_reg  <= BS_IDLE;
      bit_reg  <= 4'd0;
      sh_reg   <= 8'h00;
      cmd_reg  <= 8'h00;
      idx_reg  <= 2'd0;
      drv_reg  <= 1'b0;
      lo_reg   <= 8'h00;
      rise_reg <= RISE_RST;
      lim_reg  <= LIMIT_RST;
      resp_reg <= RESP_RST;
    end else begin
      bus_reg  <= bus_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      cmd_reg  <= cmd_next;
      idx_reg  <= idx_next;
      drv_reg  <= drv_next;
      lo_reg   <= lo_next;
      rise_reg <= rise_next;
      lim_reg  <= lim_next;
      resp_reg <= resp_next;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = drv_reg;

  // ---------------------------------------------------------------
  // startup sequencer
  // ---------------------------------------------------------------
  ssf_seq_e    st_reg, st_next;
  logic [31:0] tick_reg, tick_next;
  logic [15:0] ton_reg, ton_next;
  logic [15:0] ramp_reg, ramp_next;
  logic [15:0] dly_reg, dly_next;
  logic [2:0]  rty_reg, rty_next;
  logic        flt_reg, flt_next;
  logic        oe_reg, oe_next;
  logic        done_reg, done_next;
  logic        ms_tick, timeout_hit, retry_ok;
  logic [1:0]  sel;
  logic [2:0]  retry_field;
  logic [15:0] delay_ms;

  assign sel         = resp_reg[SEL_HI:SEL_LO];
  assign retry_field = resp_reg[RETRY_HI:RETRY_LO];
  // unit is the overvoltage fault unit, held elsewhere
  assign delay_ms    = fault_delay(resp_reg[DLY_HI:DLY_LO],
                                   ov_fault_time_unit);
  assign ms_tick     = (tick_reg == MS_CYCLES - 1);
  // a zero limit never times out
  assign timeout_hit = (st_reg == SQ_RAMP) && (lim_reg != 16'h0000) &&
                       (ton_reg >= lim_reg) && !vout_ok;
  assign retry_ok    = (retry_field == RETRY_LOOP) ||
                       (rty_reg < retry_field);

  always_comb begin
    st_next   = st_reg;
    tick_next = ms_tick ? 32'd0 : tick_reg + 32'd1;
    ton_next  = ton_reg;
    dly_next  = dly_reg;
    rty_next  = rty_reg;
    flt_next  = flt_reg;
    ramp_next = (ms_tick && ramp_reg < rise_reg) ? ramp_reg + 16'd1
                                                 : ramp_reg;
    if (clear_faults || !ramp_go) begin
      flt_next = 1'b0;
    end
    if (timeout_hit) begin
      flt_next = 1'b1; // set beats clear
    end
    if (!ramp_go) begin
      st_next  = SQ_OFF;
      rty_next = 3'd0;
    end else begin
      case (st_reg)
        SQ_OFF: begin
          st_next   = SQ_RAMP;
          ton_next  = 16'd0;
          ramp_next = 16'd0;
        end
        SQ_RAMP: begin
          if (vout_ok) begin
            st_next  = SQ_UP;
            rty_next = 3'd0;
          end else if (timeout_hit) begin
            dly_next = 16'd0;
            case (sel)
              SEL_IGNORE:  st_next = SQ_UP;
              SEL_RUN:     st_next = SQ_HOLD;
              SEL_DISABLE: st_next = retry_ok ? SQ_WAIT
                                              : SQ_LATCH;
              default:     st_next = SQ_LATCH;
            endcase
            if (sel == SEL_DISABLE && retry_ok && rty_reg != 3'd7) begin
              rty_next = rty_reg + 3'd1;
            end
          end else if (ms_tick && ton_reg != 16'hffff) begin
            ton_next = ton_reg + 16'd1;
          end
        end
        SQ_HOLD: begin
          if (vout_ok) begin
            st_next  = SQ_UP;
            rty_next = 3'd0;
          end else if (dly_reg >= delay_ms) begin
            dly_next = 16'd0;
            st_next  = retry_ok ? SQ_WAIT : SQ_LATCH;
            if (retry_ok && rty_reg != 3'd7) begin
              rty_next = rty_reg + 3'd1;
            end
          end else if (ms_tick) begin
            dly_next = dly_reg + 16'd1;
          end
        end
        SQ_WAIT: begin
          if (dly_reg >= delay_ms) begin
            st_next   = SQ_RAMP;
            ton_next  = 16'd0;
            ramp_next = 16'd0;
          end else if (ms_tick) begin
            dly_next = dly_reg + 16'd1;
          end
        end
        SQ_LATCH: begin
          // off-then-on also leaves here through SQ_OFF
          if (clear_faults) begin
            st_next  = SQ_OFF;
            rty_next = 3'd0;
          end
        end
        SQ_UP:   st_next = SQ_UP;
        default: st_next = SQ_OFF;
      endcase
    end
    oe_next = (st_next == SQ_RAMP) || (st_next == SQ_UP) ||
              (st_next == SQ_HOLD);
    if (!oe_next) begin
      ramp_next = 16'd0;
    end
    done_next = oe_next && (ramp_next >= rise_reg);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg   <= SQ_OFF;
      tick_reg <= 32'd0;
      ton_reg  <= 16'd0;
      ramp_reg <= 16'd0;
      dly_reg  <= 16'd0;
      rty_reg  <= 3'd0;
      flt_reg  <= 1'b0;
      oe_reg   <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tick_reg <= tick_next;
      ton_reg  <= ton_next;
      ramp_reg <= ramp_next;
      dly_reg  <= dly_next;
      rty_reg  <= rty_next;
      flt_reg  <= flt_next;
      oe_reg   <= oe_next;
      done_reg <= done_next;
    end
  end

  assign output_enable = oe_reg;
  assign ramp_done     = done_reg;
  assign ramp_active   = oe_reg & ~done_reg;
  assign ramp_ms       = ramp_reg;
  assign startup_fault = flt_reg;
  assign retry_count   = rty_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_timeout;
    timeout_hit && ramp_go;
  endsequence

  property p_off_ramp_zero;
    @(posedge clk) disable iff (!reset_n)
      !output_enable |-> ramp_ms == 16'd0;
  endproperty
  a_off_ramp_zero: assert property (p_off_ramp_zero)
    else $error("ramp count nonzero while output off");

  property p_timeout_flag;
    @(posedge clk) disable iff (!reset_n)
      s_timeout |=> startup_fault;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("timeout did not raise startup fault");

  property p_zero_limit;
    @(posedge clk) disable iff (!reset_n)
      lim_reg == 16'h0000 |-> !timeout_hit;
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("timeout with zero limit");

  property p_ignore;
    @(posedge clk) disable iff (!reset_n)
      s_timeout ##0 sel == SEL_IGNORE |=> output_enable[*2];
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignore mode interrupted output");

  property p_disable;
    @(posedge clk) disable iff (!reset_n)
      s_timeout ##0 sel == SEL_DISABLE |=> !output_enable;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable mode kept output on");

  property p_latch_hold;
    @(posedge clk) disable iff (!reset_n)
      st_reg == SQ_LATCH && ramp_go && !clear_faults |=> !output_enable;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("output on while latched off");

  property p_retry_bound;
    @(posedge clk) disable iff (!reset_n)
      retry_field != RETRY_LOOP && $stable(resp_reg)
        |-> rty_reg <= retry_field || $past(rty_reg) == rty_reg;
  endproperty
  a_retry_bound: assert property (p_retry_bound)
    else $error("retry count beyond programmed limit");

  property p_wait_restart;
    @(posedge clk) disable iff (!reset_n)
      st_reg == SQ_WAIT && ramp_go && dly_reg >= delay_ms
        |=> st_reg == SQ_RAMP ##0 ton_reg == 16'd0;
  endproperty
  a_wait_restart: assert property (p_wait_restart)
    else $error("restart after spacing did not restart timer");

  property p_good_clears;
    @(posedge clk) disable iff (!reset_n)
      st_reg == SQ_RAMP && ramp_go && vout_ok |=> retry_count == 3'd0;
  endproperty
  a_good_clears: assert property (p_good_clears)
    else $error("attempt count kept after good ramp");

endmodule : ssf_startup_seq

// File: shared/ssf_pkg.sv
package ssf_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RISE  = 8'h61;
  localparam logic [7:0] CMD_LIMIT = 8'h62;
  localparam logic [7:0] CMD_RESP  = 8'h63;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RISE_RST  = 16'h000a;
  localparam logic [15:0] LIMIT_RST = 16'h0032;
  localparam logic [7:0]  RESP_RST  = 8'h80;

  // ---------------------------------------------------------------
  // response byte fields
  // ---------------------------------------------------------------
  localparam int SEL_HI   = 7;
  localparam int SEL_LO   = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DLY_HI   = 2;
  localparam int DLY_LO   = 0;

  localparam logic [1:0] SEL_IGNORE  = 2'b00;
  localparam logic [1:0] SEL_RUN     = 2'b01;
  localparam logic [1:0] SEL_DISABLE = 2'b10;
  localparam logic [2:0] RETRY_LOOP  = 3'b111;

  // ---------------------------------------------------------------
  // timing and bus identity
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned CLK_PER_MS  = CLK_FREQ_HZ / MS_PER_S;
  // bus address value is arbitrary
  localparam logic [6:0]  BUS_ADDR_DEF = 7'h40;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_OFF   = 3'b000,
    SQ_RAMP  = 3'b001,
    SQ_UP    = 3'b010,
    SQ_HOLD  = 3'b011,
    SQ_WAIT  = 3'b100,
    SQ_LATCH = 3'b101
  } ssf_seq_e;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_ADDR = 3'b001,
    BS_CMD  = 3'b010,
    BS_WR   = 3'b011,
    BS_RD   = 3'b100
  } ssf_bus_e;

endpackage : ssf_pkg

// File: verif/ssf_host_model.sv
`timescale 1ns/1ps
module ssf_host_model
  import ssf_pkg::*;
#(
  parameter logic [6:0] ADDR = BUS_ADDR_DEF
) (
  // bus pins
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // ----------------------------------------------------------
  // bit cells, 48 ns each; scl stands high between frames
  // ----------------------------------------------------------
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic put_bit(input logic b);
    #12 sda_pull = !b;
    #12 scl = 1'b1;
    #24 scl = 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    #12 sda_pull = 1'b0;
    #12 scl = 1'b1;
    #12 b = sda;
    #12 scl = 1'b0;
  endtask : get_bit

  task automatic start_c();
    #12 sda_pull = 1'b0;
    #12 scl = 1'b1;
    #12 sda_pull = 1'b1;
    #12 scl = 1'b0;
  endtask : start_c

  task automatic stop_c();
    #12 sda_pull = 1'b1;
    #12 scl = 1'b1;
    #12 sda_pull = 1'b0;
    #12;
  endtask : stop_c

  // ----------------------------------------------------------
  // transfers: words low byte first, response register a byte
  // ----------------------------------------------------------
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask : rd_byte

  task automatic write(input logic [7:0] cmd, input logic [15:0] v,
                       input logic two, output logic ok);
    logic a0, a1, a2, a3;
    start_c();
    wr_byte({ADDR, 1'b0}, a0);
    wr_byte(cmd, a1);
    wr_byte(v[7:0], a2);
    a3 = 1'b1;
    if (two) wr_byte(v[15:8], a3);
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask : write

  task automatic read(input logic [7:0] cmd, output logic [15:0] v,
                      output logic ok);
    logic a0, a1, a2;
    start_c();
    wr_byte({ADDR, 1'b0}, a0);
    wr_byte(cmd, a1);
    start_c();
    wr_byte({ADDR, 1'b1}, a2);
    rd_byte(1'b0, v[7:0]);
    rd_byte(1'b1, v[15:8]);
    stop_c();
    ok = a0 & a1 & a2;
  endtask : read
endmodule : ssf_host_model

// File: verif/ssf_startup_seq_bench.sv
`timescale 1ns/1ps
module ssf_startup_seq_bench
  import ssf_pkg::*;
();
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  localparam int MS = 20;
  logic        clk, reset_n, scl, sda_pull, ramp_go, clear_faults, vout;
  logic        sda_o, sda_oe, oe, r_act, r_done, fault;
  logic [7:0]  unit, c;
  logic [15:0] r_ms, v, w;
  logic [2:0]  rcnt;
  wire  logic  sda_line;
  int          mismatches, comparisons, seed, n, d, ons, gap, toff;
  int          cycles = 0;

  // open drain with pull-up
  assign sda_line = !sda_pull & !(sda_oe & !sda_o);

  ssf_startup_seq #(.MS_CYCLES(MS)) uut (
    .clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .ramp_go(ramp_go),
    .clear_faults(clear_faults), .vout_above_uv(vout),
    .ov_fault_time_unit(unit), .output_enable(oe), .ramp_active(r_act),
    .ramp_done(r_done), .ramp_ms(r_ms), .startup_fault(fault),
    .retry_count(rcnt));

  ssf_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ms counts may run short by one tick, hence the tolerance
  task automatic near(input string nm, input int e, g, tol);
    comparisons++;
    if (g < e - tol || g > e + tol) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : near

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic regw(input logic [7:0] a, input logic [15:0] x,
                      input logic two);
    logic ok;
    host.write(a, x, two, ok);
    chk("write ack",
        16'(a == CMD_RISE || a == CMD_LIMIT || a == CMD_RESP),
        16'(ok));
  endtask : regw

  task automatic regr(input logic [7:0] a, output logic [15:0] x);
    logic ok;
    host.read(a, x, ok);
    chk("read ack", 16'h0001, 16'(ok));
  endtask : regr

  task automatic run(input logic [7:0] resp, input logic [15:0] lim);
    ramp_go = 1'b0;
    vout    = 1'b0;
    tick(4);
    regw(CMD_RESP, {8'h00, resp}, 1'b0);
    regw(CMD_LIMIT, lim, 1'b1);
    tick(1);
    ramp_go = 1'b1;
  endtask : run

  task automatic watch(input int k);
    int   off_at;
    logic prev;
    ons    = 0;
    gap    = -1;
    toff   = -1;
    off_at = -1;
    prev   = oe;
    for (int i = 0; i < k; i++) begin
      tick(1);
      if (oe && !prev) begin
        ons++;
        if (off_at >= 0) gap = i - off_at;
      end
      if (!oe && prev) begin
        off_at = i;
        if (toff < 0) toff = i;
      end
      prev = oe;
    end
  endtask : watch

  task automatic pulse_clear();
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(3);
    chk("cleared", 16'h0, 16'({fault, rcnt}));
  endtask : pulse_clear

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    reset_n      = 1'b0;
    ramp_go      = 1'b0;
    clear_faults = 1'b0;
    vout         = 1'b0;
    unit         = 8'h01;
    seed         = 22300;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("reset outs", 16'h0, 16'({oe, r_act, r_done, fault, rcnt}));
    chk("reset ramp", 16'h0, r_ms);
    tick(3);
    regr(CMD_RISE, v);
    chk("rise reset", RISE_RST, v);
    regr(CMD_LIMIT, v);
    chk("limit reset", LIMIT_RST, v);
    regr(CMD_RESP, v);
    chk("resp reset", {8'h00, RESP_RST}, v);
    for (int i = 0; i < 6; i++) begin
      c = CMD_RISE + 8'($unsigned($random(seed)) % 3);
      w = 16'($random(seed));
      regw(c, w, 1'b1);
      if (c == CMD_RESP) w = {8'h00, w[7:0]};
      regr(c, v);
      chk("readback", w, v);
    end
    regw(8'h64, 16'h1111, 1'b1);
    regw(CMD_LIMIT, 16'h0005, 1'b1);
    regw(CMD_LIMIT, 16'h00aa, 1'b0);
    regr(CMD_LIMIT, v);
    chk("lone low byte", 16'h0005, v);
    // ramp length with the timeout switched off
    w = 16'(2 + $unsigned($random(seed)) % 3);
    regw(CMD_RISE, w, 1'b1);
    run(8'h80, 16'h0000);
    tick(2);
    chk("ramp active", 16'h1, 16'(r_act));
    n = 2;
    while (r_done !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    near("ramp time", w * MS, n, MS + 4);
    chk("ramp ms", w, r_ms);
    chk("ramp idle", 16'h0, 16'(r_act));
    tick(30 * MS);
    chk("no limit", 16'h0001, 16'({fault, oe}));
    // output reaches the limit in time
    run(8'h80, 16'd4);
    tick(2 * MS);
    vout = 1'b1;
    tick(10 * MS);
    chk("good start", 16'h0010, 16'({oe, fault, rcnt}));
    run(8'h00, 16'd2);
    watch(20 * MS);
    chk("ignore", 16'h0003, 16'({oe, 1'(ons == 1)}));
    // disable and retry over every retry code
    for (int r = 0; r < 8; r++) begin
      d    = $unsigned($random(seed)) % 3;
      unit = 8'(1 + $unsigned($random(seed)) % 2);
      run({2'b10, 3'(r), 3'(d)}, 16'd2);
      watch(10 * (4 + (unit << d)) * MS);
      if (r == 7) chk("endless", 16'h1, 16'(ons > 8));
      else chk("attempts", 16'(r + 1), 16'(ons));
      chk("retries", 16'(r), {13'h0, rcnt});
      if (r > 0) near("spacing", (unit << d) * MS, gap,
                      MS + 4);
      if (r < 7) chk("stays off", 16'h1, 16'({oe, fault}));
      if (r == 3) pulse_clear();
    end
    run(8'hc0 | 8'($unsigned($random(seed)) % 64), 16'd2);
    watch(40 * MS);
    chk("latch", 16'h5, 16'({1'(ons == 1), oe, fault}));
    pulse_clear();
    // run on for the delay, then no retry
    d    = $unsigned($random(seed)) % 8;
    unit = 8'h01;
    run({5'b01000, 3'(d)}, 16'd2);
    watch((12 + (1 << d)) * MS);
    near("run on", (1 + (1 << d)) * MS, toff, MS + 6);
    chk("run on off", 16'h1, 16'({oe, fault}));
    end_of_test();
  end
endmodule : ssf_startup_seq_bench
